// >>> src/wdt_map.vh
/*
 * Register map, field positions, reset values and timing constants of the watchdog block.
 * Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define WDT_OFS_CONTROL 4'h0
`define WDT_OFS_STATUS 4'h4
`define WDT_OFS_IRQ_MASK 4'h8
`define WDT_OFS_COUNT 4'hC

// ****************************************
// Control register fields
// ****************************************
`define WDT_CTL_SWEN_BIT 0
`define WDT_CTL_PS_LSB 1
`define WDT_CTL_PS_MSB 5
`define WDT_PS_RESET 5'h0B
`define WDT_PS_MAX 5'h12
`define WDT_PS_MIN_SHIFT 5'h05
`define WDT_PS_BASE_SHIFT 5'h05

// ****************************************
// Mode configuration codes
// ****************************************
`define WDT_MODE_OFF 2'h0
`define WDT_MODE_SW 2'h1
`define WDT_MODE_NO_SLEEP 2'h2
`define WDT_MODE_ON 2'h3

// ****************************************
// Status and event bits
// ****************************************
`define WDT_EV_RESET_BIT 0
`define WDT_EV_WAKE_BIT 1
`define WDT_EV_W 2
`define WDT_STS_TO_BIT 2
`define WDT_STS_PD_BIT 3

// ****************************************
// Counter width
// ****************************************
`define WDT_CNT_W 24

`endif

// >>> src/wdt_timer.v
/*
 * Watchdog timer with AXI4-Lite register access, sticky event status and one interrupt.
 * Assumes slow_osc_clk is a free-running slow oscillator from another domain; it is
 * synchronised into ref_clk and its rising edges are counted. Other inputs are synchronous.
 * The slow clock must stay below a quarter of ref_clk, or edges would be missed.
 * Timeout requests are one-cycle pulses; the logic that owns reset and wake must
 * catch them on ref_clk. Event status bits are sticky until the status word is read.
 */
// The address map and the AXI4-Lite interface to the registers were decided locally.
// Function
// [R1] Counter advances on slow internal oscillator cycles, not the system clock.
// [R2] Mode 11: watchdog always active, also in sleep.
// [R3] Mode 10: active while awake, disabled in sleep.
// [R4] Mode 01: software enable decides; sleep changes nothing.
// [R5] Software enable bit honoured only in mode 01, ignored otherwise.
// [R6] Mode 00: watchdog disabled, counter held cleared.
// [R7] Period select resets to 01011, a 1:65536 prescale.
// [R8] Codes 00000..10010 select doubling ratios 1:32 to 1:8388608.
// [R9] Codes 10011..11111 give the minimum 1:32 interval.
// [R10] Clear on reset, clear instruction, sleep entry, wake, oscillator fail, disable.
// [R11] Wake with crystal clock holds clear until start-up timer ends.
// [R12] Enabled in sleep, counting resumes from zero after entry clear.
// [R13] Timeout in sleep wakes device and updates timeout and powerdown flags.
// [R14] Oscillator divider change leaves the counter alone.
// [R15] Timeout while awake issues a device reset.
// [R16] Timeout fires when count reaches two to the five plus code.
`include "wdt_map.vh"

module wdt_timer (
	// Clock and reset
	input wire ref_clk,
	input wire nrst,
	// Slow oscillator from its own domain
	input wire slow_osc_clk,
	// Configuration and device state
	input wire [1:0] watchdog_mode_cfg,
	input wire sleep_active,
	input wire clear_watchdog_instr,
	input wire osc_fail,
	input wire osc_startup_timer,
	input wire crystal_clock_sel,
	input wire internal_osc_divider_chg,
	// Watchdog results
	output reg wdt_reset_req,
	output reg wdt_wake_req,
	output reg timeout_flag_n,
	output reg powerdown_flag_n,
	output wire irq,
	// AXI4-Lite slave
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

	// ****************************************
	// Slow oscillator synchroniser
	// ****************************************
	reg osc_meta_q;
	reg osc_sync_q;
	reg osc_prev_q;
	wire osc_tick;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			osc_meta_q <= 1'b0;
			osc_sync_q <= 1'b0;
			osc_prev_q <= 1'b0;
		end else begin
			osc_meta_q <= slow_osc_clk;
			osc_sync_q <= osc_meta_q;
			osc_prev_q <= osc_sync_q;
		end
	end

	// Slow clock is far below ref_clk, so every edge is seen
	assign osc_tick = osc_sync_q & ~osc_prev_q; // [R1]

	// ****************************************
	// Register state
	// ****************************************
	reg [4:0] period_sel_q;
	reg sw_watchdog_enable_q;
	reg [`WDT_EV_W-1:0] status_q;
	reg [`WDT_EV_W-1:0] mask_q;
	reg [`WDT_CNT_W-1:0] count_q;
	reg sleep_prev_q;
	reg ost_hold_q;

	// ****************************************
	// Mode decode
	// ****************************************
	reg wdt_active;

	always @* begin
		case (watchdog_mode_cfg)
			`WDT_MODE_ON: wdt_active = 1'b1; // [R2]
			`WDT_MODE_NO_SLEEP: wdt_active = ~sleep_active; // [R3]
			`WDT_MODE_SW: wdt_active = sw_watchdog_enable_q; // [R4] [R5]
			`WDT_MODE_OFF: wdt_active = 1'b0; // [R6]
			default: wdt_active = 1'b0;
		endcase
	end

	// ****************************************
	// Timeout limit
	// ****************************************
	reg [`WDT_CNT_W-1:0] limit;
	reg [4:0] limit_shift;

	// Largest shift is 23, so the limit always fits the counter
	always @* begin
		if (period_sel_q > `WDT_PS_MAX)
			limit_shift = `WDT_PS_MIN_SHIFT; // [R9]
		else
			limit_shift = period_sel_q + `WDT_PS_BASE_SHIFT; // [R8] [R16]
		limit = {{(`WDT_CNT_W-1){1'b0}}, 1'b1} << limit_shift;
	end

	// ****************************************
	// Counter and clear sources
	// ****************************************
	wire sleep_enter;
	wire sleep_exit;
	wire clr_instr;
	wire clr_sleep;
	wire clr_fail;
	wire clr_disabled;
	wire clr_startup;
	wire wdt_clear;
	wire [`WDT_CNT_W-1:0] count_next;
	wire limit_hit;
	wire timeout;

	assign sleep_enter = sleep_active & ~sleep_prev_q;
	assign sleep_exit = ~sleep_active & sleep_prev_q;
	assign clr_instr = clear_watchdog_instr; // [R10]
	// Both sleep edges clear, so a sleep-time count always starts at zero
	assign clr_sleep = sleep_enter | sleep_exit; // [R10] [R12]
	assign clr_fail = osc_fail; // [R10]
	assign clr_disabled = ~wdt_active; // [R6] [R10]
	// Crystal wake keeps clearing until the start-up timer has finished
	assign clr_startup = ost_hold_q | (sleep_exit & crystal_clock_sel); // [R11]
	// Divider change is deliberately absent from the clear terms
	assign wdt_clear = clr_instr | clr_sleep | clr_fail | clr_disabled |
		clr_startup; // [R10] [R14]

	// ****************************************
	// Timeout detection
	// ****************************************
	assign count_next = count_q + {{(`WDT_CNT_W-1){1'b0}}, 1'b1}; // [R1]
	assign limit_hit = (count_next >= limit); // [R16]
	assign timeout = wdt_active & ~wdt_clear & osc_tick & limit_hit; // [R13] [R15]

	// ****************************************
	// Sleep edges and start-up hold
	// ****************************************
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sleep_prev_q <= 1'b0;
			ost_hold_q <= 1'b0;
		end else begin
			sleep_prev_q <= sleep_active;
			// Hold ends when the start-up timer stops running
			if (sleep_exit & crystal_clock_sel)
				ost_hold_q <= 1'b1; // [R11]
			else if (~osc_startup_timer)
				ost_hold_q <= 1'b0;
		end
	end

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			count_q <= {`WDT_CNT_W{1'b0}}; // [R10]
		end else begin
			if (wdt_clear | timeout)
				count_q <= {`WDT_CNT_W{1'b0}}; // [R10] [R12]
			else if (osc_tick)
				count_q <= count_next; // [R1]
		end
	end

	// ****************************************
	// Timeout actions and flags
	// ****************************************
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wdt_reset_req <= 1'b0;
			wdt_wake_req <= 1'b0;
			timeout_flag_n <= 1'b1;
			powerdown_flag_n <= 1'b1;
		end else begin
			wdt_reset_req <= timeout & ~sleep_active; // [R15]
			wdt_wake_req <= timeout & sleep_active; // [R13]
			if (timeout) begin
				timeout_flag_n <= 1'b0; // [R13]
				powerdown_flag_n <= ~sleep_active;
			end else if (sleep_enter) begin
				timeout_flag_n <= 1'b1;
				powerdown_flag_n <= 1'b0;
			end else if (clear_watchdog_instr) begin
				timeout_flag_n <= 1'b1;
				powerdown_flag_n <= 1'b1;
			end
		end
	end

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	reg aw_held_q;
	reg w_held_q;
	reg [3:0] aw_addr_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	wire do_write;

	assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
	assign do_write = aw_held_q & w_held_q;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			period_sel_q <= `WDT_PS_RESET; // [R7]
			sw_watchdog_enable_q <= 1'b0;
			mask_q <= {`WDT_EV_W{1'b0}};
		end else begin
			if (s_axi_awvalid & s_axi_awready) begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				case (aw_addr_q)
					`WDT_OFS_CONTROL: begin
						if (w_strb_q[0]) begin
							sw_watchdog_enable_q <= w_data_q[`WDT_CTL_SWEN_BIT];
							period_sel_q <= w_data_q[`WDT_CTL_PS_MSB:`WDT_CTL_PS_LSB];
						end
					end
					`WDT_OFS_IRQ_MASK: begin
						if (w_strb_q[0])
							mask_q <= w_data_q[`WDT_EV_W-1:0];
					end
					`WDT_OFS_STATUS: begin
					end
					`WDT_OFS_COUNT: begin
					end
					default: s_axi_bresp <= 2'h2;
				endcase
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// AXI4-Lite read channel and status
	// ****************************************
	wire status_rd;
	wire [`WDT_EV_W-1:0] events;

	assign s_axi_arready = ~s_axi_rvalid;
	assign status_rd = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `WDT_OFS_STATUS);
	assign events = {wdt_wake_req, wdt_reset_req};
	assign irq = |(status_q & mask_q);

	// ****************************************
	// Sticky event status
	// ****************************************
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			status_q <= {`WDT_EV_W{1'b0}};
		end else begin
			// New events win over the read-clear
			status_q <= (status_rd ? {`WDT_EV_W{1'b0}} : status_q) | events;
		end
	end

	// ****************************************
	// Read data select
	// ****************************************
	reg [31:0] rd_word;
	reg rd_err;

	// Reserved bits read as zero; unmapped offsets answer with an error
	always @* begin
		rd_word = 32'h0;
		rd_err = 1'b0;
		case (s_axi_araddr)
			`WDT_OFS_CONTROL: rd_word = {26'h0, period_sel_q, sw_watchdog_enable_q};
			`WDT_OFS_STATUS: rd_word = {28'h0, powerdown_flag_n, timeout_flag_n, status_q};
			`WDT_OFS_IRQ_MASK: rd_word = {30'h0, mask_q};
			`WDT_OFS_COUNT: rd_word = {8'h0, count_q};
			default: rd_err = 1'b1;
		endcase
	end

	// ****************************************
	// Read response
	// ****************************************
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else begin
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_err ? 2'h2 : 2'h0;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule // wdt_timer

// >>> tb/testbench.sv
/*
 * Self-checking bench for wdt_timer.
 * Assumes a fast slow oscillator (8 ref_clk period) so short codes time out quickly.
 */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 0, nrst = 0, slow_osc_clk = 0, sleep_active = 0;
	logic clear_watchdog_instr = 0, osc_fail = 0, osc_startup_timer = 0;
	logic crystal_clock_sel = 0, internal_osc_divider_chg = 0;
	logic [1:0] watchdog_mode_cfg = 2'h0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
	logic s_axi_bready = 1, s_axi_rready = 1;
	wire wdt_reset_req, wdt_wake_req, timeout_flag_n, powerdown_flag_n, irq;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	logic [2:0] div = 3'h0;
	int slow_n = 0, fail_count = 0, tests_run = 0;
	logic [31:0] d;
	logic [1:0] r;
	logic [1:0] wr_resp = 2'h0;

	wdt_timer u_wdt_timer (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.slow_osc_clk(slow_osc_clk),
		.watchdog_mode_cfg(watchdog_mode_cfg),
		.sleep_active(sleep_active),
		.clear_watchdog_instr(clear_watchdog_instr),
		.osc_fail(osc_fail),
		.osc_startup_timer(osc_startup_timer),
		.crystal_clock_sel(crystal_clock_sel),
		.internal_osc_divider_chg(internal_osc_divider_chg),
		.wdt_reset_req(wdt_reset_req),
		.wdt_wake_req(wdt_wake_req),
		.timeout_flag_n(timeout_flag_n),
		.powerdown_flag_n(powerdown_flag_n),
		.irq(irq),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready)
	);

	always #4 ref_clk = ~ref_clk;

	// Slow oscillator at an eighth of ref_clk, rising edges counted
	always @(posedge ref_clk) begin
		div <= div + 3'h1;
		slow_osc_clk <= div[2];
		if (div == 3'h4)
			slow_n <= slow_n + 1;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		tests_run++;
		if (g !== x) begin
			fail_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, x);
		end
	endtask

	// Ready is sampled mid-cycle; it only moves at the rising edge
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		logic ta, tw;
		ta = 0;
		tw = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge ref_clk);
			ta = ta | s_axi_awready;
			tw = tw | s_axi_wready;
			@(posedge ref_clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end
		do begin
			@(negedge ref_clk);
			ta = s_axi_bvalid;
			wr_resp = s_axi_bresp;
			@(posedge ref_clk);
		end while (!ta);
	endtask

	task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] e);
		logic t;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(negedge ref_clk);
			t = s_axi_arready;
			@(posedge ref_clk);
		end while (!t);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge ref_clk);
			t = s_axi_rvalid;
			v = s_axi_rdata;
			e = s_axi_rresp;
			@(posedge ref_clk);
		end while (!t);
	endtask

	// Clear, then expect a timeout after e slow edges (0: none within 80)
	task automatic run(input int e, input logic wk);
		int s;
		logic hit;
		clear_watchdog_instr <= 1'b1;
		repeat (3) @(posedge ref_clk);
		clear_watchdog_instr <= 1'b0;
		s = slow_n;
		hit = 0;
		while (!hit && slow_n - s < 80) begin
			@(negedge ref_clk);
			hit = wdt_reset_req | wdt_wake_req;
		end
		chk(hit, e != 0);
		chk(slow_n - s >= e - 1 && slow_n - s <= e + 1, hit);
		if (hit)
			chk(wdt_wake_req, wk);
		@(posedge ref_clk);
	endtask

	task automatic t_reset;
		rd(4'h0, d, r);
		chk(d, 32'h16);
		rd(4'h2, d, r);
		chk(r, 2'h2);
		chk(d, 32'h0);
		wr(4'h2, 32'h0);
		chk(wr_resp, 2'h2);
	endtask

	task automatic t_modes;
		// {mode, sw enable, sleep, 0 none / 1 reset / 2 wake}
		logic [5:0] tbl[8] = '{6'h31, 6'h21, 6'h19, 6'h10, 6'h08, 6'h36, 6'h24, 6'h1E};
		foreach (tbl[i]) begin
			watchdog_mode_cfg <= tbl[i][5:4];
			sleep_active <= tbl[i][2];
			wr(4'h0, {31'h0, tbl[i][3]});
			run(tbl[i][1:0] != 0 ? 32 : 0, tbl[i][1]);
			if (tbl[i][1])
				chk(timeout_flag_n, 1'b0);
			if (tbl[i][1:0] != 2'h0)
				chk(powerdown_flag_n, !tbl[i][2]);
			if (tbl[i][5:4] == 2'h0) begin
				rd(4'hC, d, r);
				chk(d, 32'h0);
			end
		end
	endtask

	task automatic t_period;
		logic [4:0] code[3] = '{5'h01, 5'h13, 5'h1F};
		int ex[3] = '{64, 32, 32};
		sleep_active <= 1'b0;
		watchdog_mode_cfg <= 2'h3;
		internal_osc_divider_chg <= 1'b1;
		foreach (code[i]) begin
			wr(4'h0, {26'h0, code[i], 1'b0});
			run(ex[i], 1'b0);
		end
		internal_osc_divider_chg <= 1'b0;
		wr(4'h0, 32'h0);
	endtask

	// Earlier scenarios left both sticky events set; the first read clears them
	task automatic t_irq;
		rd(4'h4, d, r);
		chk(d[1:0], 2'h3);
		wr(4'h8, 32'h1);
		run(32, 1'b0);
		@(negedge ref_clk);
		chk(irq, 1'b1);
		@(posedge ref_clk);
		rd(4'h4, d, r);
		chk(d[1:0], 2'h1);
		chk(irq, 1'b0);
		wr(4'h8, 32'h0);
		run(32, 1'b0);
		@(negedge ref_clk);
		chk(irq, 1'b0);
		@(posedge ref_clk);
	endtask

	// Crystal wake held cleared by the start-up timer, then oscillator failure
	task automatic t_clears;
		crystal_clock_sel <= 1'b1;
		osc_startup_timer <= 1'b1;
		sleep_active <= 1'b1;
		repeat (20) @(posedge ref_clk);
		sleep_active <= 1'b0;
		run(0, 1'b0);
		osc_startup_timer <= 1'b0;
		run(32, 1'b0);
		osc_fail <= 1'b1;
		run(0, 1'b0);
		osc_fail <= 1'b0;
		// Second reset in mid-run: control and status return to reset values
		nrst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		rd(4'h0, d, r);
		chk(d, 32'h16);
		rd(4'h4, d, r);
		chk(d[3:0], 4'hC);
	endtask

	task end_sim;
		if (fail_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		@(posedge ref_clk);
		t_reset;
		t_modes;
		t_period;
		t_irq;
		t_clears;
		end_sim;
	end

	initial begin
		#300us;
		fail_count++;
		end_sim;
	end
endmodule // testbench

// >>> tb/wdt_timer_checker.sv
/*
 * Port checker for wdt_timer.
 * Assumes it is bound to wdt_timer and sees only that module's ports.
 */
module wdt_chk (
	// Clock and reset
	input wire ref_clk,
	input wire nrst,
	// Watched ports
	input wire [1:0] watchdog_mode_cfg,
	input wire sleep_active,
	input wire clear_watchdog_instr,
	input wire osc_fail,
	input wire wdt_reset_req,
	input wire wdt_wake_req,
	input wire timeout_flag_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire req = wdt_reset_req | wdt_wake_req;
	// Three cycles cover the registered pulse latency
	sequence s_asleep;
		sleep_active [*3];
	endsequence
	sequence s_awake;
		!sleep_active [*3];
	endsequence
	AST_RST_ONE: assert property (wdt_reset_req |=> !wdt_reset_req)
		else $error("reset pulse too long");
	AST_WAKE_ONE: assert property (wdt_wake_req |=> !wdt_wake_req)
		else $error("wake pulse too long");
	AST_NO_RST_ASLEEP: assert property (s_asleep |-> !wdt_reset_req)
		else $error("reset while asleep");
	AST_NO_WAKE_AWAKE: assert property (s_awake |-> !wdt_wake_req)
		else $error("wake while awake");
	AST_OFF: assert property ((watchdog_mode_cfg == 2'h0) [*3] |-> !req)
		else $error("timeout in off mode");
	AST_SLEEP_OFF: assert property ((watchdog_mode_cfg == 2'h2 && sleep_active) [*3] |-> !req)
		else $error("timeout in sleep with sleep-off mode");
	AST_CLR: assert property (clear_watchdog_instr [*3] |-> !req)
		else $error("timeout while cleared");
	AST_FAIL: assert property (osc_fail [*3] |-> !req)
		else $error("timeout during oscillator failure");
	AST_TO_FLAG: assert property (wdt_wake_req |-> ##[0:1] !timeout_flag_n)
		else $error("timeout flag not low after wake");
endmodule // wdt_chk

bind wdt_timer wdt_chk u_wdt_chk (
	.ref_clk(ref_clk),
	.nrst(nrst),
	.watchdog_mode_cfg(watchdog_mode_cfg),
	.sleep_active(sleep_active),
	.clear_watchdog_instr(clear_watchdog_instr),
	.osc_fail(osc_fail),
	.wdt_reset_req(wdt_reset_req),
	.wdt_wake_req(wdt_wake_req),
	.timeout_flag_n(timeout_flag_n)
);
